// File: src/cfm_map.svh
// constants for the bus fault and mode controller
`ifndef CFM_MAP_SVH
`define CFM_MAP_SVH
`define CFM_CLK_MHZ 25
`define CFM_CYC(us) ((us) * `CFM_CLK_MHZ)
`define CFM_DOM_TMO_US 2000
`define CFM_RST_US 1000
`define CFM_UV_LIMIT_US 100000
`define CFM_AWAIT_US 75000
`define CFM_CMP_FILT_US 30
`define CFM_LOW_FAIL_US 100
`define CFM_LOW_REC_US 100
`define CFM_WAKE_FILT_US 10
`define CFM_FAIL_W 8
`define CFM_CNT_W 12
`define CFM_DOM_W 16
`define CFM_TMR_W 22
`define CFM_F1 0
`define CFM_F2 1
`define CFM_F3 2
`define CFM_F4 3
`define CFM_F5 4
`define CFM_F6 5
`define CFM_F7 6
`define CFM_F8 7
`define CFM_LP_DET_MASK 8'hcc
`define CFM_ALL_DET_MASK 8'hff
`define CFM_IRQ_SUPPLY 0
`define CFM_IRQ_FAULT 1
`define CFM_IRQ_WAKE 2
`define CFM_IRQ_W 3
`endif

// File: src/cfm_pkg.sv
// types for the bus fault and mode controller
package cfm_pkg;
	typedef enum logic [2:0] {
		CHIP_RESET, CHIP_AWAIT, CHIP_NORMAL, CHIP_STANDBY, CHIP_SLEEP
	} cfm_chip_type;
	typedef enum logic [1:0] {
		FULL_DUPLEX_BUS_MODE, LISTEN_ONLY_MODE, BUS_LOW_POWER_MODE
	} cfm_xcvr_type;
	typedef enum logic [1:0] {CMD_NORMAL, CMD_STANDBY, CMD_SLEEP} cfm_cmd_type;
	typedef struct packed {
		logic       bat_over;
		logic       bat_under;
		logic       periph_uv;
		logic       overtemp;
		logic       core_uv;
		logic       tx_dom;
		logic       canh_dom;
		logic       canl_dom;
		logic       diff_dom;
		logic       diff_below_rec;
		logic [7:0] fail_raw;
	} cfm_pins_type;
	typedef struct packed {
		logic drv_h_en;
		logic drv_l_en;
		logic high_term_gnd_switch;
		logic low_term_periph_switch;
		logic low_term_batt_switch;
		logic rx_enable;
	} cfm_bus_ctl_type;
	typedef struct packed {
		logic supply_high_flag;
		logic supply_loss_flag;
	} cfm_supply_status_type;
	typedef struct packed {
		cfm_supply_status_type supply;
		logic [7:0]            fault;
		logic [1:0]            wake;
	} cfm_evt_type;
endpackage

// File: src/cfm_evt_buf.sv
// two-entry event buffer with valid and ready on both sides
`timescale 1ns/1ns
module cfm_evt_buf #(
	parameter int W     = 12,
	parameter int DEPTH = 2
)(
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0]  mem_reg [DEPTH];
	logic [W-1:0]  mem_next [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          push, pop;

	function automatic logic [AW-1:0] fn_inc(input logic [AW-1:0] p);
		fn_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_reg != '0);
	assign o_out_data  = mem_reg[rd_reg];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_comb begin
		mem_next = mem_reg;
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		cnt_next = cnt_reg;
		if (push) begin
			mem_next[wr_reg] = i_in_data;
			wr_next          = fn_inc(wr_reg);
		end
		if (pop) begin
			rd_next = fn_inc(rd_reg);
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_next = cnt_reg - (AW+1)'(1);
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			mem_reg <= mem_next;
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule // cfm_evt_buf

// File: src/cfm_ctrl.sv
// bus transceiver fault handling and chip mode control
// Notes on behaviour
// - battery above overvoltage level sets supply-high flag and maskable interrupt, nothing else
// - transceiver mode is full duplex, listen-only or low power, chosen by host
// - listen-only: transmitter off, receiver on, rx dominant if tx or bus dominant
// - detector runs in active modes, classifies eight wire failures, picks transmission mode
// - failures 3 and 6 switch to single wire after filter, recover after filter
// - failures 4 and 7 drop low driver after timeout, recover after recessive time
// - per failure: none for 1,2,5; high side off 3,8; low side off 4,6,7
// - each failure sets own flag, cleared only when recovered and read
// - transmit dominant past timeout disables bus drivers
// - low power: drivers and receivers off, low termination to battery, partial detection
// - low power is left only by host command, never by the device itself
// - filtered bus dominance records wake source, then interrupt or leave sleep
// - after power up chip awaits configuration with transceiver in low power
// - peripheral supply undervoltage forces transceiver to low power
// - overtemperature disables only the transmitter stages
// - reset mode at power up or watchdog fault, held minimum time, then await
// - core undervoltage beyond limit: sleep or stay in reset, by build parameter
// - await mode waits for host data, sleeps on timeout after reset release
// - watchdog timing word first activates watchdog, then other writes are accepted
// - await mode keeps peripheral supply and transmitter off
// - battery below undervoltage level sets supply-loss flag and maskable interrupt
// - after peripheral supply loss mode stays low power until host rewrites it
`timescale 1ns/1ns
`include "cfm_map.svh"
module cfm_ctrl
	import cfm_pkg::*;
#(
	parameter int DOM_TMO_CYC      = `CFM_CYC(`CFM_DOM_TMO_US),
	parameter int RST_CYC          = `CFM_CYC(`CFM_RST_US),
	parameter int UV_LIMIT_CYC     = `CFM_CYC(`CFM_UV_LIMIT_US),
	parameter int AWAIT_CYC        = `CFM_CYC(`CFM_AWAIT_US),
	parameter bit SLEEP_ON_CORE_UV = 1'b1
)(
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst,
	input  wire cfm_pins_type        i_pins,
	input  wire logic                i_wd_word_wr,
	input  wire logic                i_wd_bad,
	input  wire logic                i_chip_cmd_wr,
	input  wire cfm_cmd_type         i_chip_cmd,
	input  wire logic                i_xcvr_wr,
	input  wire cfm_xcvr_type        i_xcvr_mode,
	input  wire logic                i_supply_rd,
	input  wire logic                i_fault_rd,
	input  wire logic                i_wake_rd,
	input  wire logic [2:0]          i_irq_mask,
	input  wire logic                i_evt_ready,
	output cfm_bus_ctl_type          o_bus_ctl,
	output logic                     o_rx_n,
	output cfm_supply_status_type    o_supply_status_reg,
	output logic [3:0]               o_bus_fault_status_hi,
	output logic [3:0]               o_bus_fault_status_lo,
	output logic [1:0]               o_wake_source_status,
	output logic                     o_irq_out_n,
	output cfm_chip_type             o_chip_mode,
	output cfm_xcvr_type             o_xcvr_mode,
	output logic                     o_periph_supply_en,
	output logic                     o_wd_active,
	output logic                     o_evt_valid,
	output cfm_evt_type              o_evt_data
);
	cfm_pins_type          pins_s1_reg, p;
	cfm_chip_type          chip_reg, chip_next;
	logic [`CFM_TMR_W-1:0] tmr_reg, tmr_next;
	logic                  wd_reg, wd_next;
	cfm_xcvr_type          xmode_reg, xmode_next, eff;
	logic [7:0]            fact_reg, fact_next, det_en;
	logic [`CFM_CNT_W-1:0] fcnt_reg [8];
	logic [`CFM_CNT_W-1:0] fcnt_next [8];
	logic [`CFM_DOM_W-1:0] dcnt_reg, dcnt_next;
	logic                  tmo_reg, tmo_next;
	logic [`CFM_CNT_W-1:0] wcnt_reg [2];
	logic [`CFM_CNT_W-1:0] wcnt_next [2];
	logic [1:0]            wake_hit;
	cfm_supply_status_type sup_reg, sup_next;
	logic [7:0]            fault_reg, fault_next;
	logic [1:0]            wake_reg, wake_next;
	logic                  irq_n_reg, irq_n_next;
	logic                  pend_reg, pend_next, buf_ready, new_evt;
	cfm_evt_type           pdata_reg, pdata_next;
	cfm_bus_ctl_type       ctl_reg, ctl_next;
	logic                  rx_n_reg, rx_n_next, bus_dom, tx_ok;

	function automatic logic fn_low_fail(input int i);
		fn_low_fail = (i == `CFM_F4) || (i == `CFM_F7);
	endfunction

	function automatic logic [`CFM_CNT_W-1:0] fn_thr(input int i, input logic act);
		if (fn_low_fail(i)) begin
			fn_thr = act ? `CFM_CNT_W'(`CFM_CYC(`CFM_LOW_REC_US) - 1)
			             : `CFM_CNT_W'(`CFM_CYC(`CFM_LOW_FAIL_US) - 1);
		end else begin
			fn_thr = `CFM_CNT_W'(`CFM_CYC(`CFM_CMP_FILT_US) - 1);
		end
	endfunction

	// pins cross into the clock domain
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pins_s1_reg <= '0;
			p           <= '0;
		end else begin
			pins_s1_reg <= i_pins;
			p           <= pins_s1_reg;
		end
	end

	// chip mode sequencing
	always_comb begin
		chip_next  = chip_reg;
		wd_next    = wd_reg;
		xmode_next = xmode_reg;
		tmr_next   = (tmr_reg == '1) ? tmr_reg : tmr_reg + `CFM_TMR_W'(1);
		case (chip_reg)
			CHIP_RESET: begin
				wd_next = 1'b0;
				if (!p.core_uv && tmr_reg >= `CFM_TMR_W'(RST_CYC - 1)) begin
					chip_next = CHIP_AWAIT;
					tmr_next  = '0;
				end else if (p.core_uv && SLEEP_ON_CORE_UV &&
				             tmr_reg >= `CFM_TMR_W'(UV_LIMIT_CYC - 1)) begin
					chip_next = CHIP_SLEEP;
				end
			end
			CHIP_AWAIT: begin
				if (p.core_uv) begin
					chip_next = CHIP_RESET;
					tmr_next  = '0;
				end else if (i_wd_word_wr) begin
					wd_next   = 1'b1;
					chip_next = CHIP_NORMAL;
				end else if (tmr_reg >= `CFM_TMR_W'(AWAIT_CYC - 1)) begin
					chip_next = CHIP_SLEEP;
				end
			end
			CHIP_NORMAL, CHIP_STANDBY: begin
				if (i_wd_bad || p.core_uv) begin
					chip_next = CHIP_RESET;
					tmr_next  = '0;
				end else if (i_chip_cmd_wr) begin
					case (i_chip_cmd)
						CMD_NORMAL:  chip_next = CHIP_NORMAL;
						CMD_STANDBY: chip_next = CHIP_STANDBY;
						CMD_SLEEP:   chip_next = CHIP_SLEEP;
						default:     chip_next = chip_reg;
					endcase
				end
			end
			CHIP_SLEEP: begin
				wd_next = 1'b0;
				if (|wake_hit) begin
					chip_next = CHIP_AWAIT;
					tmr_next  = '0;
				end
			end
			default: chip_next = CHIP_RESET;
		endcase
		// host write sets mode only in normal mode with watchdog active
		if (i_xcvr_wr && wd_reg && chip_reg == CHIP_NORMAL) begin
			xmode_next = i_xcvr_mode;
		end
		// stays low power after supply loss
		if (p.periph_uv || chip_next != CHIP_NORMAL) begin
			xmode_next = BUS_LOW_POWER_MODE;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			chip_reg  <= CHIP_RESET;
			tmr_reg   <= '0;
			wd_reg    <= 1'b0;
			xmode_reg <= BUS_LOW_POWER_MODE;
		end else begin
			chip_reg  <= chip_next;
			tmr_reg   <= tmr_next;
			wd_reg    <= wd_next;
			xmode_reg <= xmode_next;
		end
	end

	assign eff = (chip_reg == CHIP_NORMAL && !p.periph_uv) ? xmode_reg
	             : BUS_LOW_POWER_MODE;
	assign det_en = (eff == BUS_LOW_POWER_MODE) ? `CFM_LP_DET_MASK : `CFM_ALL_DET_MASK;

	always_comb begin
		fact_next = fact_reg;
		fcnt_next = fcnt_reg;
		for (int i = 0; i < `CFM_FAIL_W; i++) begin
			if (!det_en[i]) begin
				fact_next[i] = 1'b0;
				fcnt_next[i] = '0;
			end else if (!fact_reg[i] ? p.fail_raw[i]
			             : (fn_low_fail(i) ? p.diff_below_rec : !p.fail_raw[i])) begin
				if (fcnt_reg[i] >= fn_thr(i, fact_reg[i])) begin
					fact_next[i] = !fact_reg[i];
					fcnt_next[i] = '0;
				end else begin
					fcnt_next[i] = fcnt_reg[i] + `CFM_CNT_W'(1);
				end
			end else begin
				fcnt_next[i] = '0;
			end
		end
	end

	always_comb begin
		dcnt_next = '0;
		tmo_next  = tmo_reg & p.tx_dom;
		if (p.tx_dom && !tmo_reg) begin
			if (dcnt_reg >= `CFM_DOM_W'(DOM_TMO_CYC - 1)) begin
				tmo_next = 1'b1;
			end else begin
				dcnt_next = dcnt_reg + `CFM_DOM_W'(1);
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			wcnt_next[i] = '0;
			wake_hit[i]  = 1'b0;
			if (eff == BUS_LOW_POWER_MODE && (i == 0 ? p.canh_dom : p.canl_dom)) begin
				if (wcnt_reg[i] >= `CFM_CNT_W'(`CFM_CYC(`CFM_WAKE_FILT_US) - 1)) begin
					wcnt_next[i] = wcnt_reg[i];
					wake_hit[i]  = (wcnt_reg[i] ==
					                `CFM_CNT_W'(`CFM_CYC(`CFM_WAKE_FILT_US) - 1));
					if (wake_hit[i]) begin
						wcnt_next[i] = wcnt_reg[i] + `CFM_CNT_W'(1);
					end
				end else begin
					wcnt_next[i] = wcnt_reg[i] + `CFM_CNT_W'(1);
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			fact_reg <= '0;
			for (int i = 0; i < `CFM_FAIL_W; i++) begin
				fcnt_reg[i] <= '0;
			end
			dcnt_reg    <= '0;
			tmo_reg     <= 1'b0;
			wcnt_reg[0] <= '0;
			wcnt_reg[1] <= '0;
		end else begin
			fact_reg <= fact_next;
			fcnt_reg <= fcnt_next;
			dcnt_reg <= dcnt_next;
			tmo_reg  <= tmo_next;
			wcnt_reg <= wcnt_next;
		end
	end

	// status flags, events and interrupt
	always_comb begin
		sup_next.supply_high_flag = p.bat_over |
		                            (sup_reg.supply_high_flag & ~i_supply_rd);
		sup_next.supply_loss_flag = p.bat_under |
		                            (sup_reg.supply_loss_flag & ~i_supply_rd);
		fault_next = fact_reg | (fault_reg & ~{`CFM_FAIL_W{i_fault_rd}});
		wake_next  = wake_hit | (wake_reg & ~{2{i_wake_rd}});
		new_evt    = |(sup_next & ~sup_reg) | |(fault_next & ~fault_reg) |
		             |(wake_next & ~wake_reg);
		pend_next  = pend_reg;
		pdata_next = pdata_reg;
		if (new_evt) begin
			pend_next  = 1'b1;
			pdata_next = {sup_next, fault_next, wake_next};
		end else if (buf_ready) begin
			pend_next = 1'b0;
		end
		irq_n_next = ~(|({|wake_reg, |fault_reg, |sup_reg} & i_irq_mask));
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sup_reg   <= '0;
			fault_reg <= '0;
			wake_reg  <= '0;
			pend_reg  <= 1'b0;
			pdata_reg <= '0;
			irq_n_reg <= 1'b1;
		end else begin
			sup_reg   <= sup_next;
			fault_reg <= fault_next;
			wake_reg  <= wake_next;
			pend_reg  <= pend_next;
			pdata_reg <= pdata_next;
			irq_n_reg <= irq_n_next;
		end
	end

	cfm_evt_buf #(
		.W     ($bits(cfm_evt_type)),
		.DEPTH (2)
	) u_evt_buf (
		.i_clk_sys   (i_clk_sys),
		.i_rst       (i_rst),
		.i_in_valid  (pend_reg),
		.o_in_ready  (buf_ready),
		.i_in_data   (pdata_reg),
		.o_out_valid (o_evt_valid),
		.i_out_ready (i_evt_ready),
		.o_out_data  (o_evt_data)
	);

	// driver, switch and receive selection
	always_comb begin
		tx_ok = (eff == FULL_DUPLEX_BUS_MODE) && !tmo_reg && !p.overtemp;
		ctl_next.drv_h_en = tx_ok && !fact_reg[`CFM_F3] && !fact_reg[`CFM_F8];
		ctl_next.drv_l_en = tx_ok && !fact_reg[`CFM_F4] && !fact_reg[`CFM_F6] &&
		                    !fact_reg[`CFM_F7];
		ctl_next.high_term_gnd_switch = !fact_reg[`CFM_F3] && !fact_reg[`CFM_F8];
		ctl_next.low_term_periph_switch = (eff != BUS_LOW_POWER_MODE) &&
		                                  ctl_next.drv_l_en | (eff != BUS_LOW_POWER_MODE &&
		                                  !fact_reg[`CFM_F4] && !fact_reg[`CFM_F6] &&
		                                  !fact_reg[`CFM_F7]);
		ctl_next.low_term_batt_switch = (eff == BUS_LOW_POWER_MODE) &&
		                                !fact_reg[`CFM_F4] && !fact_reg[`CFM_F6] &&
		                                !fact_reg[`CFM_F7];
		ctl_next.rx_enable = (eff != BUS_LOW_POWER_MODE);
		if (fact_reg[`CFM_F4] || fact_reg[`CFM_F6] || fact_reg[`CFM_F7]) begin
			bus_dom = p.canh_dom;
		end else if (fact_reg[`CFM_F3] || fact_reg[`CFM_F8]) begin
			bus_dom = p.canl_dom;
		end else begin
			bus_dom = p.diff_dom;
		end
		case (eff)
			FULL_DUPLEX_BUS_MODE: rx_n_next = !bus_dom;
			LISTEN_ONLY_MODE:     rx_n_next = !(bus_dom || p.tx_dom);
			default:              rx_n_next = 1'b1;
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ctl_reg  <= '0;
			rx_n_reg <= 1'b1;
		end else begin
			ctl_reg  <= ctl_next;
			rx_n_reg <= rx_n_next;
		end
	end

	assign o_bus_ctl             = ctl_reg;
	assign o_rx_n                = rx_n_reg;
	assign o_supply_status_reg   = sup_reg;
	assign o_bus_fault_status_hi = fault_reg[7:4];
	assign o_bus_fault_status_lo = fault_reg[3:0];
	assign o_wake_source_status  = wake_reg;
	assign o_irq_out_n           = irq_n_reg;
	assign o_chip_mode           = chip_reg;
	assign o_xcvr_mode           = eff;
	assign o_periph_supply_en    = (chip_reg == CHIP_NORMAL);
	assign o_wd_active           = wd_reg;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	sequence s_rst_entry;
		chip_reg == CHIP_RESET && $past(chip_reg) != CHIP_RESET;
	endsequence
	sequence s_rst_hold;
		chip_reg == CHIP_RESET [*8];
	endsequence
	property p_supply_high;
		p.bat_over |=> sup_reg.supply_high_flag ##1 sup_reg.supply_high_flag;
	endproperty
	a_supply_high: assert property (p_supply_high) else $error("supply high lost");
	property p_listen_echo;
		eff == LISTEN_ONLY_MODE && p.tx_dom |=> !o_rx_n && !o_bus_ctl.drv_h_en;
	endproperty
	a_listen_echo: assert property (p_listen_echo) else $error("listen echo bad");
	property p_high_fail;
		fact_reg[`CFM_F3] |=> !o_bus_ctl.drv_h_en && !o_bus_ctl.high_term_gnd_switch;
	endproperty
	a_high_fail: assert property (p_high_fail) else $error("high side not off");
	property p_fault_flag;
		fact_reg[`CFM_F4] |=> fault_reg[`CFM_F4] && !o_bus_ctl.drv_l_en;
	endproperty
	a_fault_flag: assert property (p_fault_flag) else $error("fault flag missing");
	property p_dom_tmo;
		tmo_reg && p.tx_dom |=> !o_bus_ctl.drv_h_en && !o_bus_ctl.drv_l_en;
	endproperty
	a_dom_tmo: assert property (p_dom_tmo) else $error("driver on after timeout");
	property p_periph_uv;
		p.periph_uv |-> eff == BUS_LOW_POWER_MODE ##1 xmode_reg == BUS_LOW_POWER_MODE;
	endproperty
	a_periph_uv: assert property (p_periph_uv) else $error("mode not forced");
	property p_await_off;
		chip_reg == CHIP_AWAIT |-> !o_periph_supply_en ##1 !o_bus_ctl.drv_h_en;
	endproperty
	a_await_off: assert property (p_await_off) else $error("await drives bus");
	property p_rst_hold;
		s_rst_entry |-> s_rst_hold;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset too short");
	property p_sleep_wake;
		chip_reg == CHIP_SLEEP && |wake_hit |=> chip_reg == CHIP_AWAIT && |wake_reg;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("wake ignored");
endmodule // cfm_ctrl

// File: tb/cfm_host_model.sv
// event sink model standing in for the configuring host
`timescale 1ns/1ns
module cfm_host_model
	import cfm_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_stall,
	input  wire logic        i_evt_valid,
	input  wire cfm_evt_type i_evt_data,
	output logic             o_evt_ready,
	output cfm_evt_type      o_last_evt,
	output int               o_evt_count
);
	// ready changes only after the falling edge, as a slow host would
	always @(negedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_evt_ready <= 1'b0;
		end else begin
			o_evt_ready <= ~i_stall;
		end
	end
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_last_evt  <= '0;
			o_evt_count <= 0;
		end else if (i_evt_valid && o_evt_ready) begin
			o_last_evt  <= i_evt_data;
			o_evt_count <= o_evt_count + 1;
		end
	end
endmodule // cfm_host_model

// File: tb/cfm_ctrl_tb.sv
// self-checking bench for the bus fault and mode controller
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fails++; \
	$display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module cfm_ctrl_tb
	import cfm_pkg::*;
;
	logic                  i_clk_sys, i_rst, wd_wr, wd_bad, cmd_wr, x_wr, stall;
	logic                  s_rd, f_rd, w_rd, evt_valid, evt_ready, rx_n, irq_n, p_en, wd_act;
	cfm_pins_type          pins;
	cfm_cmd_type           cmd;
	cfm_xcvr_type          x_mode, x_eff;
	cfm_bus_ctl_type       bus;
	cfm_supply_status_type sup;
	cfm_chip_type          chip;
	cfm_evt_type           evt, last_evt;
	logic [3:0]            f_hi, f_lo;
	logic [2:0]            irq_mask;
	logic [1:0]            wake;
	int                    fails, samples_checked, n_evt, cycles;

	cfm_ctrl #(.DOM_TMO_CYC(40), .RST_CYC(20), .UV_LIMIT_CYC(100), .AWAIT_CYC(60),
		.SLEEP_ON_CORE_UV(1'b1)) cfm_ctrl_i (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pins(pins), .i_wd_word_wr(wd_wr),
		.i_wd_bad(wd_bad), .i_chip_cmd_wr(cmd_wr), .i_chip_cmd(cmd), .i_xcvr_wr(x_wr),
		.i_xcvr_mode(x_mode), .i_supply_rd(s_rd), .i_fault_rd(f_rd), .i_wake_rd(w_rd),
		.i_irq_mask(irq_mask), .i_evt_ready(evt_ready), .o_bus_ctl(bus), .o_rx_n(rx_n),
		.o_supply_status_reg(sup), .o_bus_fault_status_hi(f_hi),
		.o_bus_fault_status_lo(f_lo), .o_wake_source_status(wake), .o_irq_out_n(irq_n),
		.o_chip_mode(chip), .o_xcvr_mode(x_eff), .o_periph_supply_en(p_en),
		.o_wd_active(wd_act), .o_evt_valid(evt_valid), .o_evt_data(evt));
	cfm_host_model cfm_host_model_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_stall(stall),
		.i_evt_valid(evt_valid), .i_evt_data(evt), .o_evt_ready(evt_ready),
		.o_last_evt(last_evt), .o_evt_count(n_evt));

	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 12000) begin
			fails++;
			summarize();
		end
	end

	task automatic summarize();
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	task automatic wait_mode(input cfm_chip_type m, input int lim);
		for (int k = 0; k < lim && chip !== m; k++) cyc(1);
		`CHK("chip_mode", m, chip)
	endtask
	task automatic set_xcvr(input cfm_xcvr_type m);
		x_mode = m;
		x_wr = 1'b1;
		cyc(1);
		x_wr = 1'b0;
		cyc(3);
	endtask
	task automatic wd_word();
		wd_wr = 1'b1;
		cyc(1);
		wd_wr = 1'b0;
		cyc(1);
	endtask
	task automatic chip_cmd(input cfm_cmd_type c);
		cmd = c;
		cmd_wr = 1'b1;
		cyc(1);
		cmd_wr = 1'b0;
		cyc(2);
	endtask

	task automatic t_reset();
		`CHK("chip_rst", CHIP_RESET, chip)
		`CHK("xcvr_rst", BUS_LOW_POWER_MODE, x_eff)
		`CHK("irq_rst", 1'b1, irq_n)
		wait_mode(CHIP_AWAIT, 40);
		`CHK("periph_en", 1'b0, p_en)
		`CHK("drv_h", 1'b0, bus.drv_h_en)
		`CHK("batt_term", 1'b1, bus.low_term_batt_switch)
		`CHK("rx_lp", 1'b0, bus.rx_enable)
		`CHK("wd_act", 1'b0, wd_act)
		set_xcvr(FULL_DUPLEX_BUS_MODE);
		`CHK("xcvr_early", BUS_LOW_POWER_MODE, x_eff)
	endtask
	task automatic t_sleep_wake();
		wait_mode(CHIP_SLEEP, 80);
		pins.canh_dom = 1'b1;
		wait_mode(CHIP_AWAIT, 300);
		pins.canh_dom = 1'b0;
		`CHK("wake_src", 1'b1, wake[0])
		w_rd = 1'b1;
		cyc(1);
		`CHK("irq_wake", 1'b0, irq_n)
		w_rd = 1'b0;
		cyc(1);
		`CHK("wake_clr", 2'h0, wake)
		`CHK("irq_clr", 1'b1, irq_n)
	endtask
	task automatic t_normal();
		wd_word();
		`CHK("chip_norm", CHIP_NORMAL, chip)
		`CHK("wd_act", 1'b1, wd_act)
		set_xcvr(FULL_DUPLEX_BUS_MODE);
		`CHK("drv_full", 2'h3, {bus.drv_h_en, bus.drv_l_en})
		set_xcvr(LISTEN_ONLY_MODE);
		`CHK("drv_lo", 2'h0, {bus.drv_h_en, bus.drv_l_en})
		`CHK("rx_en_lo", 1'b1, bus.rx_enable)
		pins.tx_dom = 1'b1;
		cyc(5);
		`CHK("rx_echo", 1'b0, rx_n)
		pins.tx_dom = 1'b0;
		set_xcvr(FULL_DUPLEX_BUS_MODE);
		pins.overtemp = 1'b1;
		cyc(5);
		`CHK("drv_ot", 2'h0, {bus.drv_h_en, bus.drv_l_en})
		`CHK("rx_ot", 1'b1, bus.rx_enable)
		pins.overtemp = 1'b0;
		cyc(5);
	endtask
	task automatic t_fail3();
		stall = 1'b1;
		pins.fail_raw[2] = 1'b1;
		cyc(740);
		`CHK("s1_early", 1'b1, bus.high_term_gnd_switch)
		cyc(30);
		`CHK("s1_open", 1'b0, bus.high_term_gnd_switch)
		`CHK("drv_f3", 2'h1, {bus.drv_h_en, bus.drv_l_en})
		`CHK("flag_f3", 4'h4, f_lo)
		`CHK("irq_f3", 1'b0, irq_n)
		f_rd = 1'b1;
		cyc(1);
		f_rd = 1'b0;
		stall = 1'b0;
		cyc(4);
		`CHK("flag_held", 4'h4, f_lo)
		`CHK("evt_f3", 1'b1, last_evt.fault[2])
		`CHK("evt_cnt", 2, n_evt)
		pins.fail_raw[2] = 1'b0;
		cyc(790);
		`CHK("s1_back", 1'b1, bus.high_term_gnd_switch)
		f_rd = 1'b1;
		cyc(1);
		f_rd = 1'b0;
		cyc(1);
		`CHK("flag_clr", 4'h0, f_lo)
	endtask
	task automatic t_fail4();
		irq_mask = 3'h5;
		pins.fail_raw[3] = 1'b1;
		cyc(2490);
		`CHK("drv_l_early", 1'b1, bus.drv_l_en)
		cyc(20);
		`CHK("drv_f4", 2'h2, {bus.drv_h_en, bus.drv_l_en})
		`CHK("term_f4", 2'h0, {bus.low_term_periph_switch, bus.low_term_batt_switch})
		`CHK("flag_f4", 4'h8, f_lo)
		`CHK("flag_hi", 4'h0, f_hi)
		`CHK("irq_masked", 1'b1, irq_n)
		irq_mask = 3'h7;
		pins.canh_dom = 1'b1;
		cyc(4);
		`CHK("irq_unmask", 1'b0, irq_n)
		`CHK("rx_single", 1'b0, rx_n)
		pins.canh_dom = 1'b0;
		pins.fail_raw[3] = 1'b0;
		pins.diff_below_rec = 1'b1;
		cyc(2510);
		`CHK("drv_l_back", 2'h3, {bus.drv_h_en, bus.drv_l_en})
		`CHK("term_back", 1'b1, bus.low_term_periph_switch)
		pins.diff_below_rec = 1'b0;
		f_rd = 1'b1;
		cyc(1);
		f_rd = 1'b0;
		cyc(1);
		`CHK("flag_f4_clr", 4'h0, f_lo)
	endtask
	task automatic t_supply();
		pins.bat_over = 1'b1;
		pins.bat_under = 1'b1;
		cyc(5);
		`CHK("sup_flags", 2'h3, sup)
		`CHK("chip_ov", CHIP_NORMAL, chip)
		pins.bat_over = 1'b0;
		pins.bat_under = 1'b0;
		cyc(4);
		s_rd = 1'b1;
		cyc(1);
		s_rd = 1'b0;
		cyc(1);
		`CHK("sup_clr", 2'h0, sup)
	endtask
	task automatic t_periph_dom();
		pins.periph_uv = 1'b1;
		cyc(4);
		`CHK("xcvr_uv", BUS_LOW_POWER_MODE, x_eff)
		pins.periph_uv = 1'b0;
		cyc(4);
		`CHK("xcvr_stay", BUS_LOW_POWER_MODE, x_eff)
		set_xcvr(FULL_DUPLEX_BUS_MODE);
		pins.tx_dom = 1'b1;
		cyc(8);
		`CHK("drv_dom", 1'b1, bus.drv_h_en)
		cyc(40);
		`CHK("drv_tmo", 2'h0, {bus.drv_h_en, bus.drv_l_en})
		pins.tx_dom = 1'b0;
	endtask
	task automatic t_standby_uv();
		chip_cmd(CMD_STANDBY);
		`CHK("xcvr_stby", BUS_LOW_POWER_MODE, x_eff)
		`CHK("periph_stby", 1'b0, p_en)
		chip_cmd(CMD_NORMAL);
		`CHK("chip_back", CHIP_NORMAL, chip)
		`CHK("xcvr_back", BUS_LOW_POWER_MODE, x_eff)
		wd_bad = 1'b1;
		cyc(1);
		wd_bad = 1'b0;
		cyc(1);
		`CHK("chip_wdbad", CHIP_RESET, chip)
		wait_mode(CHIP_AWAIT, 25);
		wd_word();
		chip_cmd(CMD_SLEEP);
		`CHK("chip_cmdslp", CHIP_SLEEP, chip)
		pins.canh_dom = 1'b1;
		wait_mode(CHIP_AWAIT, 300);
		pins.canh_dom = 1'b0;
		pins.core_uv = 1'b1;
		wait_mode(CHIP_RESET, 6);
		wait_mode(CHIP_SLEEP, 130);
		`CHK("xcvr_slp", BUS_LOW_POWER_MODE, x_eff)
	endtask

	initial begin
		{wd_wr, wd_bad, cmd_wr, x_wr, s_rd, f_rd, w_rd, stall} = '0;
		pins = '0;
		cmd = CMD_NORMAL;
		x_mode = BUS_LOW_POWER_MODE;
		irq_mask = 3'h7;
		fails = 0;
		samples_checked = 0;
		cycles = 0;
		i_rst = 1'b1;
		cyc(5);
		i_rst = 1'b0;
		cyc(1);
		t_reset();
		t_sleep_wake();
		t_normal();
		t_fail3();
		t_fail4();
		t_supply();
		t_periph_dom();
		t_standby_uv();
		summarize();
	end
endmodule // cfm_ctrl_tb
